/* design/eci_map.vh */
// external control inputs: shared constants
// assumes a 10 MHz system clock
`ifndef ECI_MAP_VH
`define ECI_MAP_VH
`define ECI_CLK_HZ         10000000
`define ECI_DEBOUNCE_MS    10
`define ECI_DEBOUNCE_CYC   ((`ECI_CLK_HZ / 1000) * `ECI_DEBOUNCE_MS)
`define ECI_CNT_W          17
`define ECI_FLASH_MS       250
`define ECI_FLASH_CYC      ((`ECI_CLK_HZ / 1000) * `ECI_FLASH_MS)
`define ECI_FLASH_W        22
`define ECI_RDG_W          24
`define ECI_RDG_RST        24'h000000
`define ECI_SEL_LIVE       2'h0
`define ECI_SEL_MAX        2'h1
`define ECI_SEL_MIN        2'h2
`define ECI_SEL_HOLD       2'h3
`endif

/* design/eci_debounce.v */
// one control pin: three-stage synchroniser and debounce filter
// assumes pin is active low (closed to return reads low)
`timescale 1ns/1ns
`default_nettype none
module eci_debounce #(
  parameter CNT_W = 17,
  parameter [CNT_W-1:0] STABLE = 17'd100000
) (
  input  wire clk,
  input  wire rst,
  input  wire pin_n,
  output reg  level_q,
  output reg  rise_q
);
  reg             s1_q;
  reg             s2_q;
  reg             s3_q;
  reg [CNT_W-1:0] cnt_q;
  // asserted when pin grounded; count while second and third agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      cnt_q   <= {CNT_W{1'b0}};
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      s1_q   <= pin_n;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      rise_q <= 1'b0;
      if (s2_q != s3_q || (~s3_q) == level_q) begin
        cnt_q <= {CNT_W{1'b0}};
      end else if (cnt_q >= STABLE - 1'b1) begin
        cnt_q   <= {CNT_W{1'b0}};
        level_q <= ~s3_q;
        rise_q  <= ~s3_q;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* design/eci_peak_track.v */
// stored maximum and minimum of the live reading
// assumes sample_valid marks a new signed reading
`timescale 1ns/1ns
`default_nettype none
`include "eci_map.vh"
module eci_peak_track #(
  parameter W = 24
) (
  input  wire                clk,
  input  wire                rst,
  input  wire                sample_valid,
  input  wire signed [W-1:0] sample,
  input  wire                clear,
  output reg  signed [W-1:0] max_q,
  output reg  signed [W-1:0] min_q,
  output reg                 seen_q
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      max_q  <= {W{1'b0}};
      min_q  <= {W{1'b0}};
      seen_q <= 1'b0;
    end else if (clear) begin
      // a sample in the clearing cycle starts the new extremes
      seen_q <= sample_valid;
      if (sample_valid) begin
        max_q <= sample;
        min_q <= sample;
      end
    end else if (sample_valid) begin
      seen_q <= 1'b1;
      if (!seen_q || sample > max_q) begin
        max_q <= sample;
      end
      if (!seen_q || sample < min_q) begin
        min_q <= sample;
      end
    end
  end
endmodule
`default_nettype wire

/* design/eci_top.v */
// rear connector control inputs of a panel meter
// assumes pins are active low to the return and asynchronous to clk
// Notes on behaviour
// - momentary tare closure zeroes the reading once.
// - peak closed shows stored maximum, flashing.
// - valley closed shows stored minimum, flashing.
// - reset input with scope bit 0 requests full hard reset.
// - reset input with scope bit 1 clears only maximum and minimum.
// - hold grounded freezes displayed value.
// - during hold sampling, outputs and extremes keep updating.
// - lockout grounded rejects configuration changes and memory writes.
// - lockout in run mode ignores menu press entering setup.
// - print input with print enable starts one serial printout.
// - print input with latch reset enable clears latched alarms.
`timescale 1ns/1ns
`default_nettype none
`include "eci_map.vh"
module eci_top #(
  parameter W        = `ECI_RDG_W,
  parameter DEB_CYC  = `ECI_DEBOUNCE_CYC,
  parameter FLASH_CYC = `ECI_FLASH_CYC
) (
  input  wire                clk,
  input  wire                rst,
  input  wire                tare_n,
  input  wire                peak_n,
  input  wire                valley_n,
  input  wire                ext_reset_n,
  input  wire                hold_n,
  input  wire                lockout_n,
  input  wire                print_n,
  input  wire                reset_scope_select,
  input  wire                print_enable,
  input  wire                alarm_latch_reset_enable,
  input  wire                sample_valid,
  input  wire signed [W-1:0] raw_reading,
  input  wire                cfg_write_req,
  input  wire                nv_write_req,
  input  wire                menu_press,
  input  wire                run_mode,
  output reg  signed [W-1:0] live_reading_q,
  output reg                 live_valid_q,
  output reg  signed [W-1:0] display_value_q,
  output reg                 display_flash_q,
  output reg  [1:0]          display_sel_q,
  output reg  signed [W-1:0] max_reading_q,
  output reg  signed [W-1:0] min_reading_q,
  output reg                 hard_reset_q,
  output reg                 print_start_q,
  output reg                 alarm_latch_clear_q,
  output reg                 cfg_write_ok_q,
  output reg                 nv_write_ok_q,
  output reg                 setup_enter_q,
  output reg                 lockout_q
);
  localparam [`ECI_CNT_W-1:0]   DEB_N   = DEB_CYC[`ECI_CNT_W-1:0];
  localparam [`ECI_FLASH_W-1:0] FLASH_N = FLASH_CYC[`ECI_FLASH_W-1:0];

  wire tare_rise;
  wire peak_on;
  wire valley_on;
  wire reset_rise;
  wire hold_on;
  wire lock_on;
  wire print_rise;

  // tare, reset and print act on the assertion edge only
  eci_debounce #(
    .CNT_W  (`ECI_CNT_W),
    .STABLE (DEB_N)
  ) u_deb_tare (
    .clk     (clk),
    .rst     (rst),
    .pin_n   (tare_n),
    .level_q (),
    .rise_q  (tare_rise)
  );

  eci_debounce #(
    .CNT_W  (`ECI_CNT_W),
    .STABLE (DEB_N)
  ) u_deb_peak (
    .clk     (clk),
    .rst     (rst),
    .pin_n   (peak_n),
    .level_q (peak_on),
    .rise_q  ()
  );

  eci_debounce #(
    .CNT_W  (`ECI_CNT_W),
    .STABLE (DEB_N)
  ) u_deb_valley (
    .clk     (clk),
    .rst     (rst),
    .pin_n   (valley_n),
    .level_q (valley_on),
    .rise_q  ()
  );

  eci_debounce #(
    .CNT_W  (`ECI_CNT_W),
    .STABLE (DEB_N)
  ) u_deb_reset (
    .clk     (clk),
    .rst     (rst),
    .pin_n   (ext_reset_n),
    .level_q (),
    .rise_q  (reset_rise)
  );

  eci_debounce #(
    .CNT_W  (`ECI_CNT_W),
    .STABLE (DEB_N)
  ) u_deb_hold (
    .clk     (clk),
    .rst     (rst),
    .pin_n   (hold_n),
    .level_q (hold_on),
    .rise_q  ()
  );

  eci_debounce #(
    .CNT_W  (`ECI_CNT_W),
    .STABLE (DEB_N)
  ) u_deb_lock (
    .clk     (clk),
    .rst     (rst),
    .pin_n   (lockout_n),
    .level_q (lock_on),
    .rise_q  ()
  );

  eci_debounce #(
    .CNT_W  (`ECI_CNT_W),
    .STABLE (DEB_N)
  ) u_deb_print (
    .clk     (clk),
    .rst     (rst),
    .pin_n   (print_n),
    .level_q (),
    .rise_q  (print_rise)
  );

  reg  signed [W-1:0] tare_off_q;
  reg                 pv_clear_q;
  reg  [`ECI_FLASH_W-1:0] flash_cnt_q;
  reg                 flash_ph_q;
  wire signed [W-1:0] max_w;
  wire signed [W-1:0] min_w;
  wire signed [W-1:0] net_w = raw_reading - tare_off_q;

  // extremes track the tared reading, hold or not
  eci_peak_track #(
    .W (W)
  ) u_pk (
    .clk          (clk),
    .rst          (rst),
    .sample_valid (sample_valid),
    .sample       (net_w),
    .clear        (pv_clear_q),
    .max_q        (max_w),
    .min_q        (min_w),
    .seen_q       ()
  );

  // tare captures the current raw value as offset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tare_off_q <= `ECI_RDG_RST;
    end else if (tare_rise) begin
      tare_off_q <= raw_reading;
    end
  end

  // edge-triggered actions, one pulse per debounced assertion
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pv_clear_q <= 1'b0;
    end else begin
      pv_clear_q <= reset_rise & reset_scope_select;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hard_reset_q <= 1'b0;
    end else begin
      hard_reset_q <= reset_rise & ~reset_scope_select;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      print_start_q <= 1'b0;
    end else begin
      print_start_q <= print_rise & print_enable;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_latch_clear_q <= 1'b0;
    end else begin
      alarm_latch_clear_q <= print_rise & alarm_latch_reset_enable;
    end
  end

  // flash phase for stored-value display
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_cnt_q <= {`ECI_FLASH_W{1'b0}};
      flash_ph_q  <= 1'b0;
    end else if (!(peak_on | valley_on)) begin
      flash_cnt_q <= {`ECI_FLASH_W{1'b0}};
      flash_ph_q  <= 1'b0;
    end else if (flash_cnt_q >= FLASH_N - 1'b1) begin
      flash_cnt_q <= {`ECI_FLASH_W{1'b0}};
      flash_ph_q  <= ~flash_ph_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 1'b1;
    end
  end

  // display selection: peak over valley over hold over live
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      display_value_q <= `ECI_RDG_RST;
      display_sel_q   <= `ECI_SEL_LIVE;
      display_flash_q <= 1'b0;
    end else begin
      display_flash_q <= (peak_on | valley_on) & flash_ph_q;
      if (peak_on) begin
        display_sel_q   <= `ECI_SEL_MAX;
        display_value_q <= max_w;
      end else if (valley_on) begin
        display_sel_q   <= `ECI_SEL_MIN;
        display_value_q <= min_w;
      end else if (hold_on) begin
        display_sel_q   <= `ECI_SEL_HOLD;
      end else begin
        display_sel_q <= `ECI_SEL_LIVE;
        // back from a stored view: show the live reading, not the stale extreme
        if (sample_valid) begin
          display_value_q <= net_w;
        end else begin
          display_value_q <= live_reading_q;
        end
      end
    end
  end

  // live outputs keep running regardless of hold
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      live_reading_q <= `ECI_RDG_RST;
      live_valid_q   <= 1'b0;
      max_reading_q  <= `ECI_RDG_RST;
      min_reading_q  <= `ECI_RDG_RST;
    end else begin
      live_valid_q  <= sample_valid;
      max_reading_q <= max_w;
      min_reading_q <= min_w;
      if (sample_valid) begin
        live_reading_q <= net_w;
      end
    end
  end

  // lockout gating; requests are gated by the same state that lockout_q shows
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lockout_q <= 1'b0;
    end else begin
      lockout_q <= lock_on;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_write_ok_q <= 1'b0;
    end else begin
      cfg_write_ok_q <= cfg_write_req & ~lockout_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_write_ok_q <= 1'b0;
    end else begin
      nv_write_ok_q <= nv_write_req & ~lockout_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      setup_enter_q <= 1'b0;
    end else begin
      setup_enter_q <= menu_press & run_mode & ~lockout_q;
    end
  end
endmodule
`default_nettype wire

/* sim/eci_checker.sv */
// checker: port assertions for the control input block
// assumes binding to eci_top with one clock and async reset
`timescale 1ns/1ns
`default_nettype none
module eci_checker (
  input wire               clk,
  input wire               rst,
  input wire               sample_valid,
  input wire               live_valid_q,
  input wire signed [23:0] display_value_q,
  input wire               display_flash_q,
  input wire [1:0]         display_sel_q,
  input wire               lockout_q,
  input wire               cfg_write_req,
  input wire               cfg_write_ok_q,
  input wire               nv_write_req,
  input wire               nv_write_ok_q,
  input wire               menu_press,
  input wire               run_mode,
  input wire               setup_enter_q,
  input wire               hard_reset_q,
  input wire               reset_scope_select,
  input wire               print_start_q,
  input wire               print_enable,
  input wire               alarm_latch_clear_q,
  input wire               alarm_latch_reset_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_cfg_lock_block: assert property (lockout_q && cfg_write_req |=> !cfg_write_ok_q)
    else $error("cfg write passed lockout");
  a_cfg_open_pass: assert property (!lockout_q && cfg_write_req |=> cfg_write_ok_q)
    else $error("cfg write lost");
  a_nv_lock_block: assert property (lockout_q && nv_write_req |=> !nv_write_ok_q)
    else $error("nv write passed lockout");
  a_menu_lock_block: assert property (lockout_q && run_mode && menu_press |=> !setup_enter_q)
    else $error("setup entered under lockout");
  a_hold_value_frozen: assert property (display_sel_q == 2'h3 && $past(display_sel_q) == 2'h3
    |-> $stable(display_value_q)) else $error("display moved in hold");
  a_flash_stored_only: assert property (display_flash_q |-> display_sel_q[1] != display_sel_q[0])
    else $error("flash outside stored view");
  a_sample_keeps_going: assert property (sample_valid |=> live_valid_q)
    else $error("sample dropped");
  a_print_single_pulse: assert property (print_start_q |=> !print_start_q)
    else $error("print pulse too long");
  a_hard_reset_scope: assert property (hard_reset_q |-> !$past(reset_scope_select))
    else $error("hard reset with scope set");
  a_print_gate_on: assert property (print_start_q |-> $past(print_enable))
    else $error("print without enable");
  a_alarm_gate_on: assert property (alarm_latch_clear_q |-> $past(alarm_latch_reset_enable))
    else $error("alarm clear without enable");
endmodule
bind eci_top eci_checker u_chk (.*);
`default_nettype wire

/* sim/eci_sw_model.sv */
// switch model: closed contacts pull control pins to the return line
// assumes open contacts float high through pull-ups
`timescale 1ns/1ns
`default_nettype none
module eci_sw_model (
  input  wire logic [6:0] close_req,
  output logic [6:0]      pin_n
);
  assign pin_n = ~close_req;
endmodule
`default_nettype wire

/* sim/testbench.sv */
// testbench for the control input block
// assumes DEB_CYC 4 and FLASH_CYC 8; pins 0..6 tare,peak,valley,reset,hold,lock,print
`timescale 1ns/1ns
`default_nettype none
`define CHK(g,e) begin checked++; if ((g)!==(e)) begin err_total++; $display("mismatch at %0t: %0h vs %0h", $time, g, e); end end
module testbench;
  logic clk, rst, sv, scope, pen, aen, cfg, nv, menu, run, flash, lv, hard, prn, alm, cok, nok, sok, lk, f0;
  logic signed [23:0] raw, live, disp, mx, mn;
  logic [6:0] cl, pin_n;
  logic [1:0] sel;
  int err_total, checked, nh, np, na;
  // {print pin, scope, print en, alarm en, hard, print, alarm}
  logic [6:0] rows [6] = '{7'h04, 7'h52, 7'h49, 7'h5b, 7'h40, 7'h20};
  eci_sw_model u_sw (.close_req(cl), .pin_n(pin_n));
  eci_top #(.DEB_CYC(4), .FLASH_CYC(8)) DUT (.clk(clk), .rst(rst), .tare_n(pin_n[0]), .peak_n(pin_n[1]),
    .valley_n(pin_n[2]), .ext_reset_n(pin_n[3]), .hold_n(pin_n[4]), .lockout_n(pin_n[5]), .print_n(pin_n[6]),
    .reset_scope_select(scope), .print_enable(pen), .alarm_latch_reset_enable(aen), .sample_valid(sv),
    .raw_reading(raw), .cfg_write_req(cfg), .nv_write_req(nv), .menu_press(menu), .run_mode(run),
    .live_reading_q(live), .live_valid_q(lv), .display_value_q(disp), .display_flash_q(flash),
    .display_sel_q(sel), .max_reading_q(mx), .min_reading_q(mn), .hard_reset_q(hard), .print_start_q(prn),
    .alarm_latch_clear_q(alm), .cfg_write_ok_q(cok), .nv_write_ok_q(nok), .setup_enter_q(sok), .lockout_q(lk));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic samp(logic signed [23:0] v);
    @(posedge clk); sv <= 1; raw <= v;
    @(posedge clk); sv <= 0;
    cyc(4);
  endtask
  // close one pin for n cycles, count action pulses until well after release
  task automatic hit(int p, int n);
    nh = 0; np = 0; na = 0;
    @(posedge clk); cl[p] <= 1;
    repeat (n + 20) begin
      @(posedge clk);
      nh += hard; np += prn; na += alm;
      if (n-- == 1) cl[p] <= 0;
    end
  endtask
  task automatic req(logic [2:0] e);
    @(posedge clk); {cfg, nv, menu} <= 3'h7;
    @(posedge clk); {cfg, nv, menu} <= 3'h0;
    @(posedge clk);
    `CHK({cok, nok, sok}, e)
  endtask
  task print_verdict;
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rst = 1; sv = 0; raw = 0; scope = 0; pen = 0; aen = 0; cfg = 0; nv = 0; menu = 0; run = 1; cl = 0;
    cyc(8);
    rst <= 0;
    @(posedge clk);
    `CHK({hard, prn, alm, lk, sel}, 6'h00)
    foreach (rows[i]) begin
      {scope, pen, aen} <= rows[i][5:3];
      hit(rows[i][6] ? 6 : 3, 12);
      `CHK(nh, int'(rows[i][2]))
      `CHK(np, int'(rows[i][1]))
      `CHK(na, int'(rows[i][0]))
    end
    samp(7);
    `CHK({mx, mn}, {24'sh7, 24'sh7})
    samp(-3); samp(9);
    cl[1] <= 1; cyc(12);
    `CHK({sel, disp}, {2'h1, 24'sh9})
    f0 = flash; cyc(8);
    `CHK(flash, ~f0)
    cl[1] <= 0; cl[2] <= 1; cyc(12);
    `CHK({sel, disp}, {2'h2, -24'sh3})
    cl[2] <= 0; cyc(12);
    cl[4] <= 1; cyc(12);
    `CHK(sel, 2'h3)
    samp(100);
    `CHK(disp, 24'sh9)
    `CHK({live, mx}, {24'sd100, 24'sd100})
    cl[4] <= 0; cyc(12);
    samp(50); hit(0, 12); samp(80);
    `CHK(live, 24'sd30)
    cl[5] <= 1; cyc(12);
    `CHK(lk, 1'b1)
    req(3'h0);
    cl[5] <= 0; cyc(12);
    req(3'h7);
    pen <= 1'b1;
    hit(6, 2);
    `CHK(np, 0)
    scope <= 1'b1;
    hit(3, 12);
    `CHK(nh, 0)
    samp(80);
    `CHK({mx, mn}, {24'sd30, 24'sd30})
    run <= 1'b0;
    req(3'h6);
    rst <= 1'b1;
    cyc(2);
    `CHK({live, disp, mx, mn, sel, flash, lv, hard, prn, alm, cok, nok, sok, lk}, 0)
    rst <= 1'b0;
    run <= 1'b1;
    @(posedge clk);
    sv <= 1'b1;
    raw <= 24'sd4;
    @(posedge clk);
    sv <= 1'b0;
    @(posedge clk);
    `CHK({lv, live}, {1'b1, 24'sd4})
    print_verdict();
  end
endmodule
`default_nettype wire
